// file: design/flash_status_busy_erase_flags.sv
// Volatile status flags of a serial flash: ready/busy, erase suspended and
// erase error, with the operation sequencer that drives them.
// Assumes the array engine and program-error logic share i_clk.
//
// Summary of operation
// - Bit 7 reads 0 busy, 1 standby.
// - Busy device refuses new operation commands.
// - Bit 6 reads 1 while erase suspended.
// - Bit 5 set when last erase failed.
// - Erase on protected sector sets erase error.
// - Only clear-status or resets clear erase error.
// - No standby while erase error remains set.
// - Either error flag forces ready/busy to 1.
`timescale 1ns/1ps
module flash_status_busy_erase_flags
  import flash_status_pkg::*;
(
  input  wire logic                    i_clk,
  input  wire logic                    i_rst,
  input  wire logic                    i_ce,
  input  wire logic [2:0]              i_addr,
  input  wire logic [7:0]              i_wdata,
  input  wire logic                    i_we,
  input  wire logic                    i_re,
  input  wire logic                    i_array_done,
  input  wire logic                    i_array_fail,
  input  wire logic                    i_program_error_flag,
  output logic [7:0]                   o_rdata,
  output logic                         o_irq,
  output flash_status_pkg::array_req_s o_array_req,
  output logic                         o_array_hold,
  output logic                         o_array_abort
);
  import flash_status_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  op_state_e  state_reg;
  op_state_e  state_next;
  byte_t      protect_reg;
  byte_t      protect_next;
  logic [2:0] mask_reg;
  logic [2:0] mask_next;
  byte_t      rdata_reg;
  byte_t      rdata_next;
  logic       irq_reg;
  logic       irq_next;
  array_req_s req_reg;
  array_req_s req_next;
  logic       hold_reg;
  logic       hold_next;
  logic       abort_reg;
  logic       abort_next;

  // ****************************************************************
  // Sticky flags: bit 0 erase error, bits 3:1 interrupt status
  // ****************************************************************
  logic [3:0] sticky_set;
  logic [3:0] sticky_clr;
  logic [3:0] sticky_q;
  logic       erase_error_flag;
  logic [2:0] irq_status;

  assign erase_error_flag = sticky_q[0];
  assign irq_status       = sticky_q[3:1];

  sticky_bits #(
    .W (4)
  ) u_sticky (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_ce  (i_ce),
    .i_set (sticky_set),
    .i_clr (sticky_clr),
    .o_q   (sticky_q)
  );

  // ****************************************************************
  // Status view
  // ****************************************************************
  logic  ready_busy_flag;
  logic  erase_suspended_flag;
  byte_t volatile_status;

  always_comb begin
    // Error hold is not standby, yet the flag reads 1 so the host looks
    // at the error bits instead of polling forever.
    ready_busy_flag = (state_reg == ST_STANDBY)
                    | (state_reg == ST_SUSPENDED)
                    | (state_reg == ST_ERROR_HOLD)
                    | erase_error_flag
                    | i_program_error_flag;
    erase_suspended_flag = (state_reg == ST_SUSPENDED);
    volatile_status = 8'h00;
    volatile_status[`BIT_READY_BUSY]      = ready_busy_flag;
    volatile_status[`BIT_ERASE_SUSPENDED] = erase_suspended_flag;
    volatile_status[`BIT_ERASE_ERROR]     = erase_error_flag;
  end

  // ****************************************************************
  // Command decode
  // ****************************************************************
  logic       cmd_wr;
  logic [2:0] cmd_op;
  logic [2:0] cmd_sector;

  assign cmd_wr     = i_we & (i_addr == `OFS_COMMAND);
  assign cmd_op     = i_wdata[`CMD_OP_HI:`CMD_OP_LO];
  assign cmd_sector = i_wdata[`CMD_SECTOR_HI:`CMD_SECTOR_LO];

  // ****************************************************************
  // Sequencer next state
  // ****************************************************************
  logic ev_done;
  logic ev_err;
  logic ev_refused;
  logic clr_status;
  logic soft_rst;

  always_comb begin
    state_next = state_reg;
    req_next   = '0;
    hold_next  = hold_reg;
    abort_next = 1'b0;
    ev_done    = 1'b0;
    ev_err     = 1'b0;
    ev_refused = 1'b0;
    clr_status = 1'b0;
    soft_rst   = 1'b0;
    if (cmd_wr && cmd_op == `CMD_SOFT_RESET) begin
      // A software reset is taken in every state and aborts the array unless already in standby.
      soft_rst   = 1'b1;
      state_next = ST_STANDBY;
      hold_next  = 1'b0;
      abort_next = (state_reg != ST_STANDBY);
    end else begin
      if (cmd_wr && cmd_op == `CMD_CLEAR_STATUS) begin
        if (ready_busy_flag) begin
          clr_status = 1'b1;
        end else begin
          ev_refused = 1'b1;
        end
      end
      unique case (state_reg)
        ST_STANDBY: begin
          if (cmd_wr && cmd_op == `CMD_ERASE) begin
            if (protect_reg[cmd_sector]) begin
              ev_err     = 1'b1;
              state_next = ST_ERROR_HOLD;
            end else begin
              req_next   = '{valid: 1'b1, kind: OP_ERASE,
                             sector: cmd_sector};
              state_next = ST_BUSY_ERASE;
            end
          end else if (cmd_wr && cmd_op == `CMD_PROGRAM) begin
            req_next   = '{valid: 1'b1, kind: OP_PROGRAM,
                           sector: cmd_sector};
            state_next = ST_BUSY_PROG;
          end else if (cmd_wr && (cmd_op == `CMD_SUSPEND ||
                                  cmd_op == `CMD_RESUME)) begin
            ev_refused = 1'b1;
          end
        end
        ST_BUSY_ERASE: begin
          if (i_array_done) begin
            ev_done = 1'b1;
            if (i_array_fail) begin
              ev_err     = 1'b1;
              state_next = ST_ERROR_HOLD;
            end else begin
              state_next = ST_STANDBY;
            end
          end else if (cmd_wr && cmd_op == `CMD_SUSPEND) begin
            hold_next  = 1'b1;
            state_next = ST_SUSPENDED;
          end else if (cmd_wr && cmd_op != `CMD_NONE &&
                       cmd_op != `CMD_CLEAR_STATUS) begin
            ev_refused = 1'b1;
          end
        end
        ST_BUSY_PROG: begin
          // A failed program also parks in error hold, but the erase error
          // flag stays clear because the program error is reported apart.
          if (i_array_done) begin
            ev_done = 1'b1;
            if (i_program_error_flag || i_array_fail) begin
              state_next = ST_ERROR_HOLD;
            end else begin
              state_next = ST_STANDBY;
            end
          end else if (cmd_wr && cmd_op != `CMD_NONE &&
                       cmd_op != `CMD_CLEAR_STATUS) begin
            ev_refused = 1'b1;
          end
        end
        ST_SUSPENDED: begin
          // Only a resume or a software reset leaves here; new array work must wait
          // until the suspended erase has finished.
          if (cmd_wr && cmd_op == `CMD_RESUME) begin
            hold_next  = 1'b0;
            state_next = ST_BUSY_ERASE;
          end else if (cmd_wr && cmd_op != `CMD_NONE &&
                       cmd_op != `CMD_CLEAR_STATUS) begin
            ev_refused = 1'b1;
          end
        end
        ST_ERROR_HOLD: begin
          // Standby only once both error sources are gone.
          if (!(erase_error_flag && !clr_status) &&
              !ev_err && !i_program_error_flag) begin
            state_next = ST_STANDBY;
          end
          if (cmd_wr && cmd_op != `CMD_NONE &&
              cmd_op != `CMD_CLEAR_STATUS) begin
            ev_refused = 1'b1;
          end
        end
        default: begin
          state_next = ST_STANDBY;
        end
      endcase
    end
  end

  // ****************************************************************
  // Flag set and clear terms
  // ****************************************************************
  always_comb begin
    sticky_set = {ev_refused, ev_err, ev_done, ev_err};
    sticky_clr = 4'h0;
    // Of the clear terms, only the clear command and a software reset touch the error flag.
    sticky_clr[0] = clr_status | soft_rst;
    if (i_we && i_addr == `OFS_IRQ_STATUS) begin
      sticky_clr[3:1] = i_wdata[2:0];
    end
  end

  // ****************************************************************
  // Register writes, read mux and interrupt
  // ****************************************************************
  always_comb begin
    protect_next = protect_reg;
    mask_next    = mask_reg;
    // Writes to the status offset are ignored on purpose.
    if (i_we && i_addr == `OFS_IRQ_MASK) begin
      mask_next = i_wdata[2:0];
    end
    if (i_we && i_addr == `OFS_SECTOR_PROTECT) begin
      protect_next = i_wdata;
    end
    rdata_next = 8'h00;
    if (i_re) begin
      unique case (i_addr)
        `OFS_VOLATILE_STATUS: rdata_next = volatile_status;
        `OFS_IRQ_STATUS:      rdata_next = {5'h00, irq_status};
        `OFS_IRQ_MASK:        rdata_next = {5'h00, mask_reg};
        `OFS_SECTOR_PROTECT:  rdata_next = protect_reg;
        default:              rdata_next = 8'h00;
      endcase
    end
    // Registered like every output, so the line trails the status by one
    // cycle; software must not expect it in the cycle of the event.
    irq_next = |(irq_status & mask_reg);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // A low clock enable freezes the sequencer, the registers and the sticky
  // flags together, so no flag can move ahead of the state it describes.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg   <= ST_STANDBY;
      protect_reg <= `RST_SECTOR_PROTECT;
      mask_reg    <= `RST_IRQ_MASK;
      rdata_reg   <= 8'h00;
      irq_reg     <= 1'b0;
      req_reg     <= '0;
      hold_reg    <= 1'b0;
      abort_reg   <= 1'b0;
    end else if (i_ce) begin
      state_reg   <= state_next;
      protect_reg <= protect_next;
      mask_reg    <= mask_next;
      rdata_reg   <= rdata_next;
      irq_reg     <= irq_next;
      req_reg     <= req_next;
      hold_reg    <= hold_next;
      abort_reg   <= abort_next;
    end
  end

  assign o_rdata       = rdata_reg;
  assign o_irq         = irq_reg;
  assign o_array_req   = req_reg;
  assign o_array_hold  = hold_reg;
  assign o_array_abort = abort_reg;

endmodule

// file: design/flash_status_cfg.svh
// Constants for the volatile status flag block: register offsets, bit
// positions, reset values and command codes.
// Assumes inclusion by its bare name from the package and the top module.
`ifndef FLASH_STATUS_CFG_SVH
`define FLASH_STATUS_CFG_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define OFS_VOLATILE_STATUS 3'h0
`define OFS_COMMAND         3'h1
`define OFS_IRQ_STATUS      3'h2
`define OFS_IRQ_MASK        3'h3
`define OFS_SECTOR_PROTECT  3'h4

// ****************************************************************
// Status bit positions and reset values
// ****************************************************************
`define BIT_READY_BUSY      7
`define BIT_ERASE_SUSPENDED 6
`define BIT_ERASE_ERROR     5
`define RST_READY_BUSY      1'h1
`define RST_ERASE_SUSPENDED 1'h0
`define RST_ERASE_ERROR     1'h0
`define RST_IRQ_MASK        3'h0
`define RST_SECTOR_PROTECT  8'h00

// ****************************************************************
// Command register fields and codes
// ****************************************************************
`define CMD_OP_HI           2
`define CMD_OP_LO           0
`define CMD_SECTOR_HI       5
`define CMD_SECTOR_LO       3
`define CMD_NONE            3'h0
`define CMD_ERASE           3'h1
`define CMD_PROGRAM         3'h2
`define CMD_SUSPEND         3'h3
`define CMD_RESUME          3'h4
`define CMD_CLEAR_STATUS    3'h5
`define CMD_SOFT_RESET      3'h6

// ****************************************************************
// Interrupt status bit positions
// ****************************************************************
`define IRQ_OP_DONE         0
`define IRQ_ERASE_ERROR     1
`define IRQ_REFUSED         2

`endif

// file: design/flash_status_pkg.sv
// Types shared by the volatile status flag block and its surroundings.
// Assumes the constants header is on the include path.
package flash_status_pkg;
  `include "flash_status_cfg.svh"

  typedef enum logic [2:0] {
    ST_STANDBY    = 3'b000,
    ST_BUSY_ERASE = 3'b001,
    ST_BUSY_PROG  = 3'b010,
    ST_SUSPENDED  = 3'b011,
    ST_ERROR_HOLD = 3'b100
  } op_state_e;

  typedef enum logic {
    OP_ERASE   = 1'b0,
    OP_PROGRAM = 1'b1
  } op_kind_e;

  typedef struct packed {
    logic       valid;
    op_kind_e   kind;
    logic [2:0] sector;
  } array_req_s;

  typedef logic [7:0] byte_t;
endpackage

// file: design/sticky_bits.sv
// Sticky flag bits: a set raises a bit, a clear drops it, set wins.
// Assumes set and clear come from logic on the same clock.
`timescale 1ns/1ps
module sticky_bits #(
  parameter int W = 4
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic         i_ce,
  input  wire logic [W-1:0] i_set,
  input  wire logic [W-1:0] i_clr,
  output logic      [W-1:0] o_q
);

  // ****************************************************************
  // One cell per bit
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      logic bit_reg;
      logic bit_next;

      // A set in the same cycle as a clear is kept, so no event is lost.
      always_comb begin
        bit_next = i_set[g] | (bit_reg & ~i_clr[g]);
      end

      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          bit_reg <= 1'b0;
        end else if (i_ce) begin
          bit_reg <= bit_next;
        end
      end

      assign o_q[g] = bit_reg;
    end
  endgenerate

endmodule

// file: dv/flash_array_model.sv
// Behavioural array engine on the far side of the status block.
// Assumes requests and hold arrive registered on the same clock.
`timescale 1ns/1ps
module flash_array_model (
  input  wire logic                         i_clk,
  input  wire logic                         i_rst,
  input  wire flash_status_pkg::array_req_s i_req,
  input  wire logic                         i_hold,
  input  wire logic                         i_abort,
  input  wire logic [7:0]                   i_latency,
  input  wire logic                         i_fail_next,
  output logic                              o_done,
  output logic                              o_fail
);
  import flash_status_pkg::*;
  logic [7:0] count_reg;
  logic       flip_reg;
  // The fail line toggles outside done so that stale values cannot pass.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      count_reg <= 8'h00;
      flip_reg  <= 1'b0;
      o_done    <= 1'b0;
      o_fail    <= 1'b0;
    end else begin
      flip_reg <= !flip_reg;
      o_done   <= 1'b0;
      o_fail   <= flip_reg;
      if (i_req.valid) begin
        count_reg <= i_latency;
      end else if (i_abort) begin
        count_reg <= 8'h00;
      end else if (count_reg != 8'h00 && !i_hold) begin
        count_reg <= count_reg - 8'h01;
        if (count_reg == 8'h01) begin
          o_done <= 1'b1;
          o_fail <= i_fail_next;
        end
      end
    end
  end
endmodule

// file: dv/flash_status_busy_erase_flags_tb.sv
// Self-checking bench of the status flag block with an array model.
// Assumes the checker is bound to the block from its own file.
`timescale 1ns/1ps
`include "flash_status_cfg.svh"
module flash_status_busy_erase_flags_tb;
  import flash_status_pkg::*;
  localparam byte_t RDY = 8'h01 << `BIT_READY_BUSY;
  localparam byte_t SUS = 8'h01 << `BIT_ERASE_SUSPENDED;
  localparam byte_t ERR = 8'h01 << `BIT_ERASE_ERROR;
  logic       i_clk, i_rst, i_we, i_re, done, fail, fail_next;
  logic       o_irq, hold, abort;
  logic       ce, pgm_err;
  logic [2:0] i_addr;
  byte_t      i_wdata, rdata, d;
  array_req_s req;
  int         n_fail, comparisons;
  flash_status_busy_erase_flags u_dut (.i_clk(i_clk), .i_rst(i_rst),
    .i_ce(ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_we(i_we),
    .i_re(i_re), .i_array_done(done), .i_array_fail(fail),
    .i_program_error_flag(pgm_err), .o_rdata(rdata), .o_irq(o_irq),
    .o_array_req(req), .o_array_hold(hold), .o_array_abort(abort));
  flash_array_model u_array (.i_clk(i_clk), .i_rst(i_rst), .i_req(req),
    .i_hold(hold), .i_abort(abort), .i_latency(8'h14),
    .i_fail_next(fail_next), .o_done(done), .o_fail(fail));
  // ****************************************************************
  // Bus tasks
  // ****************************************************************
  task automatic chk(input string n, input byte_t e, input byte_t g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [2:0] a, input byte_t v);
    i_re <= 1'b0; i_we <= 1'b1; i_addr <= a; i_wdata <= v;
    @(posedge i_clk);
  endtask
  task automatic idle(input int n);
    i_we <= 1'b0; i_re <= 1'b0;
    repeat (n) @(posedge i_clk);
  endtask
  task automatic rdc(input string n, input logic [2:0] a, input byte_t e);
    i_we <= 1'b0; i_re <= 1'b1; i_addr <= a;
    @(posedge i_clk);
    i_re <= 1'b0;
    @(negedge i_clk) chk(n, e, rdata);
    @(posedge i_clk);
  endtask
  // Back-to-back status reads, as the host does before its next command.
  task automatic poll_ready(input byte_t e);
    i_we <= 1'b0; i_re <= 1'b1; i_addr <= `OFS_VOLATILE_STATUS;
    for (int k = 0; k < 200; k++) begin
      @(posedge i_clk);
      @(negedge i_clk) d = rdata;
      if (d[7] === 1'b1) break;
    end
    chk("status", e, d);
    @(posedge i_clk);
    i_re <= 1'b0;
    @(posedge i_clk);
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset_values();
    rdc("status", `OFS_VOLATILE_STATUS, RDY);
    // A write while the clock enable is low must leave the mask alone.
    ce <= 1'b0;
    wr(`OFS_IRQ_MASK, 8'h07);
    ce <= 1'b1;
    rdc("mask", `OFS_IRQ_MASK, 8'h00);
    rdc("protect", `OFS_SECTOR_PROTECT, 8'h00);
    rdc("unmapped", 3'h7, 8'h00);
  endtask
  task automatic t_erase_ok();
    wr(`OFS_IRQ_MASK, 8'h01);
    wr(`OFS_COMMAND, 8'h01);
    rdc("status", `OFS_VOLATILE_STATUS, 8'h00);
    wr(`OFS_COMMAND, 8'h02);
    rdc("irq", `OFS_IRQ_STATUS, 8'h04);
    poll_ready(RDY);
    rdc("irq", `OFS_IRQ_STATUS, 8'h05);
    chk("irq_out", 8'h01, {7'h00, o_irq});
    wr(`OFS_IRQ_STATUS, 8'h07);
    idle(3);
    chk("irq_out", 8'h00, {7'h00, o_irq});
  endtask
  task automatic t_suspend();
    wr(`OFS_COMMAND, 8'h09);
    wr(`OFS_COMMAND, 8'h03);
    idle(2);
    rdc("status", `OFS_VOLATILE_STATUS, RDY | SUS);
    idle(30);
    rdc("status", `OFS_VOLATILE_STATUS, RDY | SUS);
    wr(`OFS_COMMAND, 8'h04);
    idle(2);
    poll_ready(RDY);
  endtask
  task automatic t_failed();
    fail_next <= 1'b1;
    wr(`OFS_COMMAND, 8'h01);
    poll_ready(RDY | ERR);
    wr(`OFS_VOLATILE_STATUS, 8'h00);
    rdc("status", `OFS_VOLATILE_STATUS, RDY | ERR);
    wr(`OFS_COMMAND, 8'h01);
    idle(2);
    rdc("status", `OFS_VOLATILE_STATUS, RDY | ERR);
    fail_next <= 1'b0;
    wr(`OFS_COMMAND, 8'h05);
    idle(2);
    rdc("status", `OFS_VOLATILE_STATUS, RDY);
  endtask
  task automatic t_protected();
    wr(`OFS_SECTOR_PROTECT, 8'h04);
    wr(`OFS_COMMAND, 8'h11);
    idle(2);
    rdc("status", `OFS_VOLATILE_STATUS, RDY | ERR);
    wr(`OFS_COMMAND, 8'h06);
    idle(2);
    rdc("status", `OFS_VOLATILE_STATUS, RDY);
    wr(`OFS_COMMAND, 8'h11);
    idle(2);
    rdc("status", `OFS_VOLATILE_STATUS, RDY | ERR);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    rdc("status", `OFS_VOLATILE_STATUS, RDY);
    rdc("protect", `OFS_SECTOR_PROTECT, 8'h00);
  endtask
  task automatic t_prog_error();
    wr(`OFS_COMMAND, 8'h02);
    rdc("status", `OFS_VOLATILE_STATUS, 8'h00);
    pgm_err <= 1'b1;
    rdc("status", `OFS_VOLATILE_STATUS, RDY);
    idle(25);
    rdc("status", `OFS_VOLATILE_STATUS, RDY);
    wr(`OFS_COMMAND, 8'h01);
    rdc("irq", `OFS_IRQ_STATUS, 8'h05);
    pgm_err <= 1'b0;
    idle(2);
    wr(`OFS_COMMAND, 8'h01);
    rdc("status", `OFS_VOLATILE_STATUS, 8'h00);
    poll_ready(RDY);
  endtask
  // ****************************************************************
  // Run control
  // ****************************************************************
  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  initial begin
    repeat (5000) @(posedge i_clk);
    n_fail++;
    complete_run();
  end
  initial begin
    i_rst = 1'b1; i_we = 1'b0; i_re = 1'b0; i_addr = 3'h0;
    i_wdata = 8'h00; fail_next = 1'b0; n_fail = 0; comparisons = 0;
    ce = 1'b1;
    pgm_err = 1'b0;
    repeat (16) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    t_reset_values();
    t_erase_ok();
    t_suspend();
    t_failed();
    t_protected();
    t_prog_error();
    complete_run();
  end
endmodule

// file: dv/flash_status_sva.sv
// Port checker of the status flag block.
// Assumes one clock domain and bus strobes one cycle long.
`timescale 1ns/1ps
`include "flash_status_cfg.svh"
module flash_status_sva (
  input wire logic                        i_clk,
  input wire logic                        i_rst,
  input wire logic                        i_ce,
  input wire logic [2:0]                  i_addr,
  input wire logic [7:0]                  i_wdata,
  input wire logic                        i_we,
  input wire logic                        i_re,
  input wire logic                        i_array_done,
  input wire logic                        i_array_fail,
  input wire logic                        i_program_error_flag,
  input wire logic [7:0]                  o_rdata,
  input wire logic                        o_irq,
  input wire flash_status_pkg::array_req_s o_array_req,
  input wire logic                        o_array_hold,
  input wire logic                        o_array_abort
);
  import flash_status_pkg::*;
  // ****************************************************************
  // Sequences and properties
  // ****************************************************************
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  sequence s_rd;
    i_re && i_addr == `OFS_VOLATILE_STATUS;
  endsequence
  sequence s_fail;
    i_array_done && i_array_fail;
  endsequence
  sequence s_ok;
    i_array_done && !i_array_fail;
  endsequence
  logic       cmd_ev;
  logic [2:0] op;
  assign cmd_ev = i_we && i_addr == `OFS_COMMAND;
  assign op     = i_wdata[2:0];
  AST_RDATA_IDLE: assert property (
    !$past(i_re) |-> o_rdata == 8'h00)
    else $error("read data not zero outside a read");
  AST_STATUS_SPARE: assert property (
    s_rd |=> o_rdata[4:0] == 5'h00)
    else $error("unused status bits not zero");
  AST_BUSY_REQ: assert property (
    ((o_array_req.valid && !i_program_error_flag) and s_rd)
    |=> !o_rdata[7])
    else $error("ready seen while operation starts");
  AST_REQ_CAUSE: assert property (
    o_array_req.valid |->
    $past(cmd_ev && (op == `CMD_ERASE || op == `CMD_PROGRAM)))
    else $error("request without erase or program command");
  AST_REQ_PULSE: assert property (
    o_array_req.valid |=> !o_array_req.valid)
    else $error("request accepted while busy");
  AST_HOLD_CAUSE: assert property (
    $rose(o_array_hold) |-> $past(cmd_ev && op == `CMD_SUSPEND))
    else $error("hold without suspend command");
  AST_HOLD_READ: assert property (
    (o_array_hold and s_rd) |=> o_rdata[7:5] == 3'h6)
    else $error("suspended flag wrong during hold");
  AST_FAIL_ERR: assert property (
    s_fail ##1 s_rd |=> o_rdata[7:5] == 3'h5)
    else $error("failed erase not flagged");
  AST_DONE_READY: assert property (
    s_ok ##1 s_rd |=> o_rdata[7:5] == 3'h4)
    else $error("ready not shown after good erase");
  AST_ABORT_CAUSE: assert property (
    o_array_abort |-> $past(cmd_ev && op == `CMD_SOFT_RESET))
    else $error("abort without software reset");
  AST_WR_STATUS: assert property (
    i_we && i_addr == `OFS_VOLATILE_STATUS |=>
    !o_array_req.valid && !o_array_abort)
    else $error("status write caused activity");
  AST_PGM_READY: assert property (
    (i_program_error_flag and s_rd) |=> o_rdata[7])
    else $error("ready not forced by program error");
endmodule
bind flash_status_busy_erase_flags flash_status_sva u_sva (.*);
